// ===== rtl/fbm_defs.svh
// Address map, field positions, reset values and counts of the frame buffer manager
`ifndef FBM_DEFS_SVH
`define FBM_DEFS_SVH

// ==============================================================
// Register indices (byte address = index * 4)
`define FBM_IDX_POLICY 16'h0001
`define FBM_IDX_CFG1 16'h0004
`define FBM_IDX_WINDOW 16'h0005
`define FBM_IDX_GAP 16'h0006
`define FBM_IDX_TEST 16'h0701
`define FBM_IDX_DEBUG 16'h0706

// ==============================================================
// Field positions
`define FBM_POLICY_CONT 0
`define FBM_CFG1_MASK_HI 2
`define FBM_CFG1_MASK_LO 0
`define FBM_CFG1_SEQ_EN 3
`define FBM_TEST_FORCE_BUSY 9
`define FBM_TEST_BUSY_OFF 10
`define FBM_TS_HI 10
`define FBM_TS_LO 3

// ==============================================================
// Reset values and constants
`define FBM_WINDOW_RST 16'h0002
`define FBM_GAP_RST 16'h0002
`define FBM_BC_MAX 12'hDEB
`define FBM_FLAGS_REJECT 4'h8
`define FBM_ALL_MASKED 3'h7
`define FBM_SLICE_LAST 2'h2
`define FBM_FIRE_LEAD 16'h0002

`endif

// ===== rtl/fbm_pkg.sv
// Types shared by the frame buffer manager modules
package fbm_pkg;

    typedef enum logic {RD_IDLE, RD_ACTIVE} read_state_t;

    typedef struct packed {
        logic meta;
        logic stable;
    } sync_state_t;

    typedef struct packed {
        logic [11:0] count;
    } counter_state_t;

    typedef struct packed {
        logic [15:0] policy;
        logic [15:0] window;
        logic [15:0] cfg1;
        logic [15:0] gap;
        logic [15:0] testCtl;
        logic wbAck;
        logic [31:0] wbDat;
        logic trigD1;
        logic strobeOn;
        logic [15:0] strobeCnt;
        logic [1:0] wp;
        logic [1:0] rp;
        logic [2:0] occupied;
        logic [2:0][7:0] sliceTs;
        logic [2:0] sliceExt;
        read_state_t rdState;
        logic busyFlag;
        logic seqRunning;
        logic gapWait;
        logic [15:0] gapCnt;
        logic [2:0] capture;
        logic [2:0] bankSel;
        logic headerValid;
        logic [7:0] headerTs;
        logic trailerValid;
        logic [3:0] trailerFlags;
        logic readoutAbort;
        logic rejectPacket;
        logic [7:0] rejectTs;
        logic [3:0] rejectFlags;
        logic busyOut;
    } fbm_state_t;

endpackage : fbm_pkg

// ===== rtl/level_sync.sv
// Two-stage synchroniser for a level arriving from a pin
`timescale 1ns/10ps
`default_nettype none

module level_sync (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic asyncIn,
    output logic syncOut
);
    import fbm_pkg::*;

    sync_state_t r_reg;
    sync_state_t r_next;

    // First stage feeds only the second stage
    always_comb begin
        r_next = r_reg;
        r_next.meta = asyncIn;
        r_next.stable = r_reg.meta;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign syncOut = r_reg.stable;

endmodule : level_sync

`default_nettype wire

// ===== rtl/crossing_counter.sv
// Free-running crossing counter with wrap and command clear
`timescale 1ns/10ps
`default_nettype none
`include "fbm_defs.svh"

module crossing_counter #(
    parameter logic [11:0] MAX_COUNT = `FBM_BC_MAX
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clearCmd,
    output logic [11:0] count
);
    import fbm_pkg::*;

    counter_state_t r_reg;
    counter_state_t r_next;

    always_comb begin
        r_next = r_reg;
        if (clearCmd) begin
            r_next.count = '0;
        end else if (r_reg.count >= MAX_COUNT) begin
            r_next.count = '0;
        end else begin
            r_next.count = r_reg.count + 12'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign count = r_reg.count;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_counter_wrap: assert property ((count == MAX_COUNT && !clearCmd) |=> count == 12'h000)
        else $error("crossing counter did not wrap");
    chk_counter_clear: assert property (clearCmd |=> count == 12'h000)
        else $error("crossing counter not cleared");

endmodule : crossing_counter

`default_nettype wire

// ===== rtl/frame_buffer_manager.sv
// Frame buffer manager: capture windows, slice rotation and Wishbone registers
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "fbm_defs.svh"

module frame_buffer_manager (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [17:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    input wire logic triggerIn,
    input wire logic crossingCounterClearCmd,
    input wire logic busyLinePin,
    input wire logic readoutDone,
    output logic [2:0] capturePulse,
    output logic [2:0] readoutBankSelect,
    output logic headerValid,
    output logic [7:0] headerTimestamp,
    output logic trailerValid,
    output logic [3:0] trailerFlags,
    output logic readoutAbort,
    output logic rejectPacket,
    output logic [7:0] rejectTimestamp,
    output logic [3:0] rejectFlags,
    output logic frameManagerBusy,
    output logic [11:0] crossingCount
);
    import fbm_pkg::*;

    // ==============================================================
    // Helpers
    function automatic logic [2:0] sliceOneHot(input logic [1:0] p);
        sliceOneHot = 3'h1 << p;
    endfunction : sliceOneHot

    // Next enabled slice after p, wrapping; stays on p if it is the only one
    function automatic logic [1:0] nextSlice(input logic [1:0] p, input logic [2:0] en);
        logic [1:0] c;
        logic found;
        nextSlice = p;
        found = 1'b0;
        c = p;
        for (int i = 0; i < 3; i++) begin
            c = (c == `FBM_SLICE_LAST) ? 2'h0 : c + 2'h1;
            if (!found && en[c]) begin
                nextSlice = c;
                found = 1'b1;
            end
        end
    endfunction : nextSlice

    function automatic logic [1:0] freeCount(input logic [2:0] occ, input logic [2:0] en);
        logic [2:0] f;
        f = en & ~occ;
        freeCount = {1'b0, f[0]} + {1'b0, f[1]} + {1'b0, f[2]};
    endfunction : freeCount

    function automatic logic [15:0] mergeWrite(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] sel);
        mergeWrite = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : mergeWrite

    // ==============================================================
    // Submodules
    logic busySync;

    level_sync busySyncer (
        .core_clk(core_clk),
        .reset(reset),
        .asyncIn(busyLinePin),
        .syncOut(busySync)
    );

    crossing_counter #(
        .MAX_COUNT(`FBM_BC_MAX)
    ) crossingCounter (
        .core_clk(core_clk),
        .reset(reset),
        .clearCmd(crossingCounterClearCmd),
        .count(crossingCount)
    );

    // ==============================================================
    // State
    localparam fbm_state_t RESET_STATE = '{
        window: `FBM_WINDOW_RST,
        gap: `FBM_GAP_RST,
        rdState: RD_IDLE,
        default: '0
    };

    fbm_state_t r_reg;
    fbm_state_t r_next;

    logic [15:0] regIdx;
    logic [2:0] enabled;
    logic [15:0] winLen;
    logic [15:0] gapLen;
    logic continuous;
    logic forceBusy;
    logic busyEff;
    logic sliceFull;
    logic flushNow;
    logic intFire;
    logic [7:0] bcTs;

    assign regIdx = wbAdr[17:2];
    assign continuous = r_reg.policy[`FBM_POLICY_CONT];
    assign forceBusy = r_reg.testCtl[`FBM_TEST_FORCE_BUSY];
    assign busyEff = busySync & ~r_reg.testCtl[`FBM_TEST_BUSY_OFF];
    assign bcTs = crossingCount[`FBM_TS_HI:`FBM_TS_LO];
    // A zero window setting is run as a one-cycle window
    assign winLen = (r_reg.window == 16'h0000) ? 16'h0001 : r_reg.window;
    assign gapLen = r_reg.gap;
    assign enabled = (r_reg.cfg1[`FBM_CFG1_MASK_HI:`FBM_CFG1_MASK_LO] == `FBM_ALL_MASKED)
                     ? 3'h7 : ~r_reg.cfg1[`FBM_CFG1_MASK_HI:`FBM_CFG1_MASK_LO];
    assign sliceFull = r_reg.occupied[r_reg.wp] | forceBusy;
    assign flushNow = r_reg.trigD1 && !r_reg.strobeOn && !sliceFull && continuous
                      && freeCount(r_reg.occupied, enabled) == 2'h1
                      && r_reg.rdState == RD_ACTIVE;
    // Fires two cycles before the next window so that the low gap equals any setting of two or more
    assign intFire = r_reg.seqRunning && r_reg.gapWait
                     && (r_reg.gapCnt + `FBM_FIRE_LEAD >= gapLen);

    always_comb begin
        r_next = r_reg;
        r_next.wbAck = 1'b0;
        r_next.headerValid = 1'b0;
        r_next.trailerValid = 1'b0;
        r_next.readoutAbort = 1'b0;
        r_next.rejectPacket = 1'b0;

        // ==========================================================
        // Wishbone slave: one wait state, unmapped reads zero
        if (wbCyc && wbStb && !r_reg.wbAck) begin
            r_next.wbAck = 1'b1;
            unique case (regIdx)
                `FBM_IDX_POLICY: r_next.wbDat = {16'h0000, r_reg.policy};
                `FBM_IDX_CFG1: r_next.wbDat = {16'h0000, r_reg.cfg1};
                `FBM_IDX_WINDOW: r_next.wbDat = {16'h0000, r_reg.window};
                `FBM_IDX_GAP: r_next.wbDat = {16'h0000, r_reg.gap};
                `FBM_IDX_TEST: r_next.wbDat = {16'h0000, r_reg.testCtl};
                `FBM_IDX_DEBUG: r_next.wbDat = {22'h000000, r_reg.seqRunning,
                    r_reg.rdState == RD_ACTIVE, r_reg.strobeOn, r_reg.rp, r_reg.wp,
                    r_reg.occupied};
                default: r_next.wbDat = 32'h00000000;
            endcase
        end
        // Write lands at the edge where the master samples ack high
        if (wbCyc && wbStb && wbWe && r_reg.wbAck) begin
            unique case (regIdx)
                `FBM_IDX_POLICY: r_next.policy = mergeWrite(r_reg.policy, wbDatW, wbSel);
                `FBM_IDX_CFG1: r_next.cfg1 = mergeWrite(r_reg.cfg1, wbDatW, wbSel);
                `FBM_IDX_WINDOW: r_next.window = mergeWrite(r_reg.window, wbDatW, wbSel);
                `FBM_IDX_GAP: r_next.gap = mergeWrite(r_reg.gap, wbDatW, wbSel);
                `FBM_IDX_TEST: r_next.testCtl = mergeWrite(r_reg.testCtl, wbDatW, wbSel);
                default: ;
            endcase
        end

        // ==========================================================
        // Sequencer control and trigger pipeline
        if (!r_reg.cfg1[`FBM_CFG1_SEQ_EN]) begin
            r_next.seqRunning = 1'b0;
            r_next.gapWait = 1'b0;
        end else if (triggerIn && !r_reg.seqRunning) begin
            r_next.seqRunning = 1'b1;
        end
        r_next.trigD1 = triggerIn | intFire;
        if (r_reg.gapWait) begin
            r_next.gapCnt = r_reg.gapCnt + 16'h0001;
        end
        if (intFire) begin
            r_next.gapWait = 1'b0;
        end

        // ==========================================================
        // Capture windows
        if (r_reg.trigD1) begin
            if (r_reg.strobeOn) begin
                r_next.strobeCnt = '0;
                r_next.sliceExt[r_reg.wp] = 1'b1;
            end else if (sliceFull) begin
                r_next.rejectPacket = 1'b1;
                r_next.rejectTs = bcTs;
                r_next.rejectFlags = `FBM_FLAGS_REJECT;
            end else begin
                r_next.strobeOn = 1'b1;
                r_next.strobeCnt = '0;
                r_next.sliceTs[r_reg.wp] = bcTs;
                r_next.sliceExt[r_reg.wp] = 1'b0;
            end
            // An external trigger re-times a running sequence
            r_next.gapWait = 1'b0;
        end else if (r_reg.strobeOn) begin
            if (r_reg.strobeCnt + 16'h0001 >= winLen) begin
                r_next.strobeOn = 1'b0;
                r_next.occupied[r_reg.wp] = 1'b1;
                r_next.wp = nextSlice(r_reg.wp, enabled);
                r_next.gapWait = r_reg.seqRunning && r_next.seqRunning;
                r_next.gapCnt = '0;
            end else begin
                r_next.strobeCnt = r_reg.strobeCnt + 16'h0001;
            end
        end else if (!enabled[r_reg.wp]) begin
            // A new mask can leave the idle write pointer on a disabled slice
            r_next.wp = nextSlice(r_reg.wp, enabled);
        end

        // ==========================================================
        // Readout sequencing
        if (flushNow) begin
            r_next.occupied[r_reg.rp] = 1'b0;
            r_next.rp = nextSlice(r_reg.rp, enabled);
            r_next.rdState = RD_IDLE;
            r_next.readoutAbort = 1'b1;
            r_next.trailerValid = 1'b1;
            r_next.trailerFlags = {1'b0, 1'b1, r_reg.sliceExt[r_reg.rp],
                                   r_reg.busyFlag | busyEff};
        end else if (r_reg.rdState == RD_IDLE && r_reg.occupied[r_reg.rp]) begin
            r_next.rdState = RD_ACTIVE;
            r_next.headerValid = 1'b1;
            r_next.headerTs = r_reg.sliceTs[r_reg.rp];
            r_next.busyFlag = 1'b0;
        end else if (r_reg.rdState == RD_ACTIVE) begin
            if (busyEff) begin
                r_next.busyFlag = 1'b1;
            end
            if (readoutDone) begin
                r_next.occupied[r_reg.rp] = 1'b0;
                r_next.rp = nextSlice(r_reg.rp, enabled);
                r_next.rdState = RD_IDLE;
                r_next.trailerValid = 1'b1;
                r_next.trailerFlags = {1'b0, 1'b0, r_reg.sliceExt[r_reg.rp],
                                       r_reg.busyFlag | busyEff};
            end
        end else if (!r_reg.occupied[r_reg.rp] && !enabled[r_reg.rp]) begin
            // Same for the idle read pointer, so it follows the write pointer
            r_next.rp = nextSlice(r_reg.rp, enabled);
        end

        // Pointer outputs follow the next state so they line up with it
        r_next.capture = r_next.strobeOn ? sliceOneHot(r_next.wp) : 3'h0;
        r_next.bankSel = (r_next.rdState == RD_ACTIVE) ? sliceOneHot(r_next.rp) : 3'h0;
        r_next.busyOut = forceBusy | (freeCount(r_next.occupied, enabled) == 2'h0);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            r_reg <= RESET_STATE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wbDatR = r_reg.wbDat;
    assign wbAck = r_reg.wbAck;
    assign capturePulse = r_reg.capture;
    assign readoutBankSelect = r_reg.bankSel;
    assign headerValid = r_reg.headerValid;
    assign headerTimestamp = r_reg.headerTs;
    assign trailerValid = r_reg.trailerValid;
    assign trailerFlags = r_reg.trailerFlags;
    assign readoutAbort = r_reg.readoutAbort;
    assign rejectPacket = r_reg.rejectPacket;
    assign rejectTimestamp = r_reg.rejectTs;
    assign rejectFlags = r_reg.rejectFlags;
    assign frameManagerBusy = r_reg.busyOut;

    // ==============================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_slices_disjoint: assert property ($onehot0(capturePulse) && $onehot0(readoutBankSelect)
        && (capturePulse & readoutBankSelect) == 3'h0)
        else $error("capture and bank select overlap");
    chk_strobe_delay: assert property ($rose(|capturePulse) |-> $past(triggerIn, 2)
        || $past(intFire, 2))
        else $error("capture rose without trigger two cycles earlier");
    chk_window_bound: assert property (r_reg.strobeOn |-> r_reg.strobeCnt < winLen)
        else $error("window ran past its duration");
    chk_extend_restart: assert property ((r_reg.strobeOn && r_reg.trigD1) |=>
        (r_reg.strobeOn && r_reg.strobeCnt == 16'h0000 && r_reg.sliceExt[r_reg.wp]))
        else $error("window not extended");
    chk_reject_full: assert property ((r_reg.trigD1 && !r_reg.strobeOn && sliceFull) |=>
        (rejectPacket && rejectFlags == `FBM_FLAGS_REJECT && capturePulse == 3'h0))
        else $error("full trigger not rejected");
    chk_window_stamp: assert property ((r_reg.trigD1 && !r_reg.strobeOn && !sliceFull) |=>
        (r_reg.sliceTs[r_reg.wp] == $past(bcTs) && capturePulse != 3'h0))
        else $error("timestamp not latched at window start");
    chk_readout_start: assert property ((r_reg.rdState == RD_IDLE && r_reg.occupied[r_reg.rp])
        |=> (headerValid && readoutBankSelect != 3'h0))
        else $error("readout did not start");
    chk_readout_end: assert property ((r_reg.rdState == RD_ACTIVE && readoutDone && !flushNow)
        |=> (trailerValid && readoutBankSelect == 3'h0 && !trailerFlags[2]))
        else $error("readout completion not handled");
    chk_flush_flag: assert property (flushNow |=> (readoutAbort && trailerFlags[2]))
        else $error("flush not reported");
    chk_force_busy: assert property (forceBusy |=> frameManagerBusy)
        else $error("forced busy not shown");

    cov_extend: cover property (r_reg.strobeOn && r_reg.trigD1);
    cov_reject: cover property (rejectPacket);
    cov_flush: cover property (readoutAbort);
    cov_seq_fire: cover property (intFire ##2 $rose(|capturePulse));

endmodule : frame_buffer_manager

`default_nettype wire

// ===== sim/readout_model.sv
// Readout control stand-in: ends each selected frame after a settable latency
`timescale 1ns/10ps
`default_nettype none

module readout_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [2:0] bankSel,
    input wire logic [15:0] latency,
    output logic readoutDone
);
    logic [15:0] wait_reg;
    logic done_reg;

    assign readoutDone = done_reg;

    // Done only while a bank is selected; a flush drops the bank and restarts the wait
    always_ff @(posedge core_clk) begin
        if (reset || bankSel == 3'h0 || done_reg) begin
            wait_reg <= 16'h0000;
            done_reg <= 1'b0;
        end else begin
            wait_reg <= wait_reg + 16'h0001;
            done_reg <= (wait_reg >= latency);
        end
    end
endmodule : readout_model

`default_nettype wire

// ===== sim/frame_buffer_manager_tb.sv
// Self-checking bench of the frame buffer manager with a readout stand-in
`timescale 1ns/10ps
`default_nettype none
`include "fbm_defs.svh"

module frame_buffer_manager_tb;
    logic core_clk = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic triggerIn = 1'b0, crossingCounterClearCmd = 1'b0, busyLinePin = 1'b0;
    logic [17:0] wbAdr = 18'h00000;
    logic [3:0] wbSel = 4'hF;
    logic [31:0] wbDatW = 32'h00000000, wbDatR, q;
    logic wbAck, readoutDone, headerValid, trailerValid, readoutAbort, rejectPacket;
    logic frameManagerBusy, hit;
    logic [2:0] capturePulse, readoutBankSelect;
    logic [7:0] headerTimestamp, rejectTimestamp;
    logic [3:0] trailerFlags, rejectFlags;
    logic [11:0] crossingCount, ts;
    logic [15:0] lat = 16'h0003;
    int errTotal = 0, checkCount = 0, cycles = 0, W, G, m;

    frame_buffer_manager dut_u (.core_clk, .reset, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
        .wbDatW, .wbDatR, .wbAck, .triggerIn, .crossingCounterClearCmd, .busyLinePin,
        .readoutDone, .capturePulse, .readoutBankSelect, .headerValid, .headerTimestamp,
        .trailerValid, .trailerFlags, .readoutAbort, .rejectPacket, .rejectTimestamp,
        .rejectFlags, .frameManagerBusy, .crossingCount);
    readout_model model_u (.core_clk(core_clk), .reset(reset), .bankSel(readoutBankSelect),
        .latency(lat), .readoutDone(readoutDone));

    always #4 core_clk = ~core_clk;

    // ====================
    // Helpers
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // Hang guard well above the longest expected run
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errTotal++;
            print_verdict;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [15:0] idx, input logic [15:0] d);
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbDatW <= {16'h0000, d};
        do @(posedge core_clk); while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : wb

    // Leaves the caller 1 ns into the cycle where capture should rise
    task automatic trig;
        @(posedge core_clk);
        triggerIn <= 1'b1;
        @(posedge core_clk);
        triggerIn <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask : trig

    task automatic span(input logic hi, output int n);
        n = 1;
        repeat (300) begin
            @(posedge core_clk);
            #1;
            if ((capturePulse !== 3'h0) !== hi) break;
            n++;
        end
    endtask : span

    task automatic trailer(input logic [3:0] f);
        repeat (300) begin
            @(posedge core_clk);
            #1;
            if (trailerValid === 1'b1) break;
        end
        chk({trailerValid, trailerFlags, readoutBankSelect}, {1'b1, f, 3'h0});
    endtask : trailer

    task automatic rst;
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
    endtask : rst

    task automatic rot(input logic [2:0] mask, input logic cont);
        logic [2:0] s, em;
        int k;
        rst;
        lat <= 16'hFFFF;
        em = (mask == 3'h7) ? 3'h0 : mask;
        k = 3 - $countones(em);
        s = 3'h1;
        wb(1'b1, `FBM_IDX_POLICY, {15'h0000, cont});
        wb(1'b1, `FBM_IDX_WINDOW, W[15:0]);
        wb(1'b1, `FBM_IDX_CFG1, {13'h0000, mask});
        for (int i = 0; i < k; i++) begin
            while ((em & s) != 3'h0) s = {s[1:0], s[2]};
            trig;
            chk(capturePulse, s);
            if (cont && i == 2) chk({readoutAbort, trailerValid, trailerFlags}, 6'h34);
            span(1'b1, m);
            s = {s[1:0], s[2]};
        end
        if (!cont) begin
            trig;
            ts = crossingCount - 12'h001;
            chk({rejectPacket, rejectFlags, capturePulse, frameManagerBusy}, 9'h181);
            chk(rejectTimestamp, ts[10:3]);
        end
        $display("test rotation mask %h policy %0d done", mask, cont);
    endtask : rot

    // ====================
    // Main sequence
    initial begin
        void'($urandom(32'hA72BB490));
        W = 2 + $urandom % 6;
        G = 2 + $urandom % 5;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        wb(1'b0, `FBM_IDX_POLICY, 16'h0000);
        chk(q, 0);
        wb(1'b0, `FBM_IDX_WINDOW, 16'h0000);
        chk(q, `FBM_WINDOW_RST);
        wb(1'b1, `FBM_IDX_WINDOW, W[15:0]);
        wb(1'b0, `FBM_IDX_WINDOW, 16'h0000);
        chk(q, W);
        wb(1'b0, 16'h0002, 16'h0000);
        chk(q, 0);
        $display("test registers done");

        trig;
        ts = crossingCount - 12'h001;
        chk(capturePulse, 3'h1);
        span(1'b1, m);
        chk(m, W);
        @(posedge core_clk);
        #1;
        chk({headerValid, readoutBankSelect, headerTimestamp}, {1'b1, 3'h1, ts[10:3]});
        trailer(4'h0);
        wb(1'b1, `FBM_IDX_TEST, 16'h0400);
        busyLinePin <= 1'b1;
        trig;
        triggerIn <= 1'b1;
        @(posedge core_clk);
        triggerIn <= 1'b0;
        #1;
        span(1'b1, m);
        chk(m, W + 1);
        trailer(4'h2);
        wb(1'b1, `FBM_IDX_TEST, 16'h0000);
        trig;
        chk(capturePulse, 3'h4);
        trailer(4'h1);
        busyLinePin <= 1'b0;
        wb(1'b1, `FBM_IDX_TEST, 16'h0200);
        trig;
        chk({rejectPacket, capturePulse, frameManagerBusy}, 5'h11);
        $display("test timing and flags done");

        rot(3'h0, 1'b0);
        rot(3'h2, 1'b0);
        rot(3'h7, 1'b0);
        rot($urandom % 7, 1'b0);
        rot(3'h0, 1'b1);

        rst;
        lat <= 16'h0001;
        wb(1'b1, `FBM_IDX_GAP, G[15:0]);
        wb(1'b1, `FBM_IDX_WINDOW, W[15:0]);
        wb(1'b1, `FBM_IDX_CFG1, 16'h0008);
        trig;
        span(1'b1, m);
        span(1'b0, m);
        chk(m, G);
        span(1'b1, m);
        chk(m, W);
        wb(1'b1, `FBM_IDX_CFG1, 16'h0000);
        repeat (W + G + 10) @(posedge core_clk);
        hit = 1'b0;
        repeat (3 * (W + G)) begin
            @(posedge core_clk);
            hit |= |capturePulse;
        end
        chk(hit, 0);
        $display("test sequencer done");

        @(posedge core_clk);
        crossingCounterClearCmd <= 1'b1;
        @(posedge core_clk);
        crossingCounterClearCmd <= 1'b0;
        #1;
        chk(crossingCount, 0);
        repeat (4000) begin
            @(posedge core_clk);
            #1;
            if (crossingCount === `FBM_BC_MAX) break;
        end
        chk(crossingCount, `FBM_BC_MAX);
        @(posedge core_clk);
        #1;
        chk(crossingCount, 0);
        $display("test crossing counter done");
        print_verdict;
    end
endmodule : frame_buffer_manager_tb

`default_nettype wire
